// ### logic/xdr_decode.sv
// Move decoder that steers each external move to the on-chip RAM or the bus.
`timescale 1ns/1ps
module xdr_decode
   import xdr_pkg::*;
(
   input  wire logic        mclk_in,          // 50 MHz clock.
   input  wire logic        rst_b_in,         // Async reset, active low.
   input  wire logic        sfr_wr_in,        // Special register write.
   input  wire logic        sfr_rd_in,        // Special register read.
   input  wire logic [7:0]  sfr_addr_in,      // Special register address.
   input  wire logic [7:0]  sfr_wdata_in,     // Special register data.
   output logic      [7:0]  sfr_rdata_out,    // Read data, next cycle.
   input  wire logic        move_start_in,    // First cycle of a move.
   input  wire logic        move_wide_in,     // Wide pointer, else short.
   input  wire logic        move_write_in,    // Write, else read.
   input  wire logic [15:0] wide_ptr_in,      // Wide data pointer value.
   input  wire logic [7:0]  short_ptr_in,     // Short pointer register.
   input  wire logic [7:0]  acc_wdata_in,     // Accumulator write data.
   output logic      [7:0]  acc_rdata_out,    // Read data to accumulator.
   output logic             acc_valid_out,    // Read data valid pulse.
   input  wire logic        ext_access_in,    // External-access pin level.
   input  wire logic [7:0]  p0_in,            // Port 0 pin levels.
   output logic      [7:0]  p0_out,           // Port 0 drive value.
   output logic             p0_oe_b_out,      // Port 0 drives when low.
   output logic      [7:0]  p2_out,           // Port 2 drive value.
   output logic             rd_b_out,         // Read strobe, active low.
   output logic             wr_b_out,         // Write strobe, active low.
   output logic             ram_disable_out   // Disable bit state.
);
   import xdr_pkg::*;

   //------------------------------------------------------------------
   // Reset release
   //------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_sync_b;

   always_ff @(posedge mclk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_b <= rst_meta_q;
      end
   end

   function automatic logic ram_hit(input logic [15:0] addr);
      ram_hit = (addr >= RAM_BASE);
   endfunction

   //------------------------------------------------------------------
   // Special registers
   //------------------------------------------------------------------
   logic [7:0] page_q, page_d, p0_lat_q, p0_lat_d, p2_lat_q, p2_lat_d;
   logic [7:0] sfr_rdata_d;
   logic       dis_q, dis_d, vis_q, vis_d;

   always_comb begin
      page_d      = page_q;
      p0_lat_d    = p0_lat_q;
      p2_lat_d    = p2_lat_q;
      dis_d       = dis_q;
      vis_d       = vis_q;
      sfr_rdata_d = ZERO_BYTE;
      if (sfr_wr_in) begin
         case (sfr_addr_in)
            SFR_PORT0: p0_lat_d = sfr_wdata_in;
            SFR_PORT2: begin
               p2_lat_d = sfr_wdata_in;
               page_d   = sfr_wdata_in;
            end
            SFR_PAGE: page_d = sfr_wdata_in;
            SFR_SYSCTL: begin
               // The disable bit can only fall under software control.
               dis_d = dis_q & sfr_wdata_in[BIT_DISABLE];
               vis_d = sfr_wdata_in[BIT_VISIBLE];
            end
            default: ;
         endcase
      end
      if (sfr_rd_in) begin
         case (sfr_addr_in)
            SFR_PORT0:  sfr_rdata_d = p0_lat_q;
            SFR_PORT2:  sfr_rdata_d = p2_lat_q;
            SFR_PAGE:   sfr_rdata_d = page_q;
            SFR_SYSCTL: begin
               sfr_rdata_d[BIT_DISABLE] = dis_q;
               sfr_rdata_d[BIT_VISIBLE] = vis_q;
            end
            default: sfr_rdata_d = ZERO_BYTE;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         page_q        <= PAGE_RST;
         p0_lat_q      <= PORT_RST;
         p2_lat_q      <= PORT_RST;
         dis_q         <= 1'b1;
         vis_q         <= 1'b0;
         sfr_rdata_out <= ZERO_BYTE;
      end else begin
         page_q        <= page_d;
         p0_lat_q      <= p0_lat_d;
         p2_lat_q      <= p2_lat_d;
         dis_q         <= dis_d;
         vis_q         <= vis_d;
         sfr_rdata_out <= sfr_rdata_d;
      end
   end

   //------------------------------------------------------------------
   // Move sequencer and pin steering
   //------------------------------------------------------------------
   xdr_state_e state_q, state_d;
   xdr_cmd_s   cmd_q, cmd_d;
   xdr_route_s rt_q, rt_d;
   xdr_pins_s  pins_q, pins_d;
   logic [7:0] acc_d, ram_rdata;
   logic       acc_valid_d, start_ok, ram_re, ram_we;

   assign start_ok = (state_q == ST_IDLE) && move_start_in;
   // Reading at the start edge lets the RAM byte reach port 0 in cycle two.
   assign ram_re   = start_ok && rt_d.use_ram;
   // The write commits on the edge that ends cycle one, so a reset there
   // cancels it and a reset later cannot undo it.
   assign ram_we   = (state_q == ST_C1) && cmd_q.write && rt_q.use_ram;

   always_comb begin
      state_d     = state_q;
      cmd_d       = cmd_q;
      rt_d        = rt_q;
      acc_d       = acc_rdata_out;
      acc_valid_d = 1'b0;
      if (start_ok) begin
         cmd_d.wide  = move_wide_in;
         cmd_d.write = move_write_in;
         cmd_d.wdata = acc_wdata_in;
         cmd_d.addr  = move_wide_in ? wide_ptr_in
                                    : {page_q, short_ptr_in};
      end
      // Visibility only counts once the RAM is really selected.
      rt_d.use_ram = ram_hit(cmd_d.addr) && !dis_q;
      rt_d.strobe  = !rt_d.use_ram || vis_q;
      rt_d.p0_bus  = rt_d.strobe || !ext_access_in;
      rt_d.p2_bus  = cmd_d.wide && rt_d.p0_bus;
      case (state_q)
         ST_IDLE: if (move_start_in) state_d = ST_C1;
         ST_C1:   state_d = ST_C2;
         ST_C2: begin
            state_d = ST_IDLE;
            if (!cmd_q.write) begin
               acc_d       = rt_q.use_ram ? ram_rdata : p0_in;
               acc_valid_d = 1'b1;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      pins_d.p0      = p0_lat_d;
      pins_d.p0_oe_b = 1'b0;
      pins_d.p2      = p2_lat_d;
      pins_d.rd_b    = 1'b1;
      pins_d.wr_b    = 1'b1;
      if (state_d != ST_IDLE) begin
         if (rt_d.p2_bus) begin
            pins_d.p2 = cmd_d.addr[15:8];
         end
         if (rt_d.p0_bus) begin
            pins_d.p0 = cmd_d.addr[7:0];
         end
      end
      if (state_d == ST_C2 && rt_d.p0_bus) begin
         if (cmd_d.write) begin
            pins_d.p0 = cmd_d.wdata;
         end else if (rt_d.use_ram) begin
            pins_d.p0 = ram_rdata;
         end else begin
            pins_d.p0_oe_b = 1'b1;
         end
      end
      if (state_d == ST_C2 && rt_d.strobe) begin
         pins_d.rd_b = cmd_d.write;
         pins_d.wr_b = !cmd_d.write;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         state_q       <= ST_IDLE;
         cmd_q         <= '0;
         rt_q          <= '0;
         acc_rdata_out <= ZERO_BYTE;
         acc_valid_out <= 1'b0;
         pins_q        <= {PORT_RST, 1'b0, PORT_RST, 1'b1, 1'b1};
      end else begin
         state_q       <= state_d;
         cmd_q         <= cmd_d;
         rt_q          <= rt_d;
         acc_rdata_out <= acc_d;
         acc_valid_out <= acc_valid_d;
         pins_q        <= pins_d;
      end
   end

   assign p0_out          = pins_q.p0;
   assign p0_oe_b_out     = pins_q.p0_oe_b;
   assign p2_out          = pins_q.p2;
   assign rd_b_out        = pins_q.rd_b;
   assign wr_b_out        = pins_q.wr_b;
   assign ram_disable_out = dis_q;

   xdr_ram u_ram (
      .clk_in    (mclk_in),
      .we_in     (ram_we),
      .waddr_in  (cmd_q.addr[RAM_AW-1:0]),
      .wdata_in  (cmd_q.wdata),
      .re_in     (ram_re),
      .raddr_in  (cmd_d.addr[RAM_AW-1:0]),
      .rdata_out (ram_rdata)
   );

   //------------------------------------------------------------------
   // Checks
   //------------------------------------------------------------------
   property p_page_follows_p2;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      sfr_wr_in && sfr_addr_in == SFR_PORT2
         |=> page_q == $past(sfr_wdata_in) && p2_lat_q == page_q;
   endproperty
   a_page_follows_p2: assert property (p_page_follows_p2)
      else $error("page register did not follow a port 2 write");

   property p_page_only;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      sfr_wr_in && sfr_addr_in == SFR_PAGE |=> $stable(p2_lat_q);
   endproperty
   a_page_only: assert property (p_page_only)
      else $error("page write changed the port 2 latch");

   property p_disable_sticky;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      !dis_q |=> !dis_q;
   endproperty
   a_disable_sticky: assert property (p_disable_sticky)
      else $error("disable bit was set again without reset");

   property p_low_wide_external;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && move_wide_in && wide_ptr_in < RAM_BASE
         |-> ##1 !p0_oe_b_out && !ram_we && p2_out == $past(wide_ptr_in[15:8])
             ##1 (rd_b_out != wr_b_out);
   endproperty
   a_low_wide_external: assert property (p_low_wide_external)
      else $error("low wide move was not an external bus cycle");

   property p_short_ram_write;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && !move_wide_in && move_write_in && ram_hit({page_q, 8'h00})
         && !dis_q |=> ram_we;
   endproperty
   a_short_ram_write: assert property (p_short_ram_write)
      else $error("short pointer write missed the on-chip RAM");

   property p_disabled_external;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && dis_q |-> ##1 !ram_we ##1 (rd_b_out != wr_b_out);
   endproperty
   a_disabled_external: assert property (p_disabled_external)
      else $error("disabled RAM did not give an external cycle");

   property p_quiet_io;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && rt_d.use_ram && !vis_q && ext_access_in
         |-> ##1 (rd_b_out && wr_b_out && p0_out == p0_lat_q)[*2];
   endproperty
   a_quiet_io: assert property (p_quiet_io)
      else $error("hidden RAM access disturbed the ports");

   property p_short_p2_io;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && !move_wide_in |-> ##1 p2_out == p2_lat_q;
   endproperty
   a_short_p2_io: assert property (p_short_p2_io)
      else $error("port 2 left I/O on a short pointer move");

   property p_read_return;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && !move_write_in |-> ##2 !acc_valid_out ##1 acc_valid_out;
   endproperty
   a_read_return: assert property (p_read_return)
      else $error("read data not returned at end of the move");

   property p_visible_strobe;
      @(posedge mclk_in) disable iff (!rst_sync_b)
      start_ok && rt_d.use_ram && vis_q |-> ##2 (rd_b_out != wr_b_out);
   endproperty
   a_visible_strobe: assert property (p_visible_strobe)
      else $error("visible RAM access gave no strobe");
endmodule

// ### logic/xdr_pkg.sv
// Package with the constants and carriers of the external-data RAM decoder.
//---------------------------------------------------------------------------
// Functional notes
//---------------------------------------------------------------------------
// Functional notes
// - Wide-pointer moves hit the on-chip RAM only at F800h-FFFFh while enabled.
// - Short-pointer RAM moves use the page register as A15-A8, pointer low.
// - Each write to the port 2 latch also loads the page register.
// - A write to the page register changes only the page register.
// - Short-pointer moves hit the RAM only for page F8h-FFh while enabled.
// - Short-pointer addresses outside the RAM range go to the external bus.
// - Reset never alters the RAM contents.
// - Reset in the first move cycle abandons the RAM write.
// - Reset in the second move cycle lets the RAM write complete.
// - RAM disabled: all moves external with strobes; port 2 I/O for short.
// - Visibility set: RAM moves show strobes and bus; port 2 I/O for short.
// - Bits clear, access pin low: no strobes, bus ports still carry data.
// - Bits clear, access pin high: no strobes, ports stay latch-driven I/O.
// - External short-pointer moves: port 0 bus, strobe active, port 2 I/O.
// - Wide moves below the RAM range are always external, both bus ports.
// - Reset sets the disable bit; software may clear it but never set it.
// - The visibility bit does nothing outside the RAM range or if disabled.
package xdr_pkg;

   localparam int          RAM_AW         = 11;
   localparam int          RAM_DEPTH      = 2048;
   localparam logic [15:0] RAM_BASE       = 16'hF800;
   localparam logic [7:0]  SFR_PORT0      = 8'h80;
   localparam logic [7:0]  SFR_PAGE       = 8'h91;
   localparam logic [7:0]  SFR_PORT2      = 8'hA0;
   localparam logic [7:0]  SFR_SYSCTL     = 8'hB1;
   localparam int          BIT_DISABLE    = 0;
   localparam int          BIT_VISIBLE    = 1;
   localparam logic [7:0]  PAGE_RST       = 8'h00;
   localparam logic [7:0]  PORT_RST       = 8'hFF;
   localparam logic [7:0]  ZERO_BYTE      = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_C1   = 3'b010,
      ST_C2   = 3'b100
   } xdr_state_e;

   typedef struct packed {
      logic        wide;
      logic        write;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } xdr_cmd_s;

   typedef struct packed {
      logic use_ram;
      logic strobe;
      logic p0_bus;
      logic p2_bus;
   } xdr_route_s;

   typedef struct packed {
      logic [7:0] p0;
      logic       p0_oe_b;
      logic [7:0] p2;
      logic       rd_b;
      logic       wr_b;
   } xdr_pins_s;

endpackage

// ### logic/xdr_ram.sv
// On-chip external-data RAM: 2 Kbyte, registered read data, no reset.
`timescale 1ns/1ps
module xdr_ram
   import xdr_pkg::*;
(
   input  wire logic              clk_in,    // Block clock.
   input  wire logic              we_in,     // Write enable.
   input  wire logic [RAM_AW-1:0] waddr_in,  // Write address.
   input  wire logic [7:0]        wdata_in,  // Write data.
   input  wire logic              re_in,     // Read enable.
   input  wire logic [RAM_AW-1:0] raddr_in,  // Read address.
   output logic      [7:0]        rdata_out  // Registered read data.
);
   logic [7:0] mem [RAM_DEPTH];

   // No reset reaches the array, so contents survive any reset.
   always_ff @(posedge clk_in) begin
      if (we_in) begin
         mem[waddr_in] <= wdata_in;
      end
      if (re_in) begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule

// ### verif/test_onchip_xdata_ram_access_decode.sv
// Self-checking testbench of the external-data RAM decoder.
`timescale 1ns/1ps
module test_onchip_xdata_ram_access_decode;
   import xdr_pkg::*;
   logic mclk_in = 0, rst_b_in = 0, sfr_wr_in = 0, sfr_rd_in = 0;
   logic move_start_in = 0, move_wide_in = 0, move_write_in = 0;
   logic ext_access_in = 0, p0_oe_b_out, acc_valid_out, rd_b_out, wr_b_out;
   logic ram_disable_out;
   logic [7:0] sfr_addr_in = 0, sfr_wdata_in = 0, short_ptr_in = 0;
   logic [7:0] acc_wdata_in = 0, sfr_rdata_out, acc_rdata_out, p0_out;
   logic [7:0] p2_out, mem_data, p0_wire, c1_p0, c1_p2, c2_p0, rdat;
   logic [15:0] wide_ptr_in = 0;
   logic c2_rd, c2_wr, c2_oe, vld;
   int n_fail = 0, n_checks = 0;
   always #10 mclk_in = ~mclk_in;
   // Port 0 wire: the block wins while it drives, else the memory.
   assign p0_wire = p0_oe_b_out ? mem_data : p0_out;
   xdr_decode u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in),
      .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_addr_in(sfr_addr_in),
      .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
      .move_start_in(move_start_in), .move_wide_in(move_wide_in),
      .move_write_in(move_write_in), .wide_ptr_in(wide_ptr_in),
      .short_ptr_in(short_ptr_in), .acc_wdata_in(acc_wdata_in),
      .acc_rdata_out(acc_rdata_out), .acc_valid_out(acc_valid_out),
      .ext_access_in(ext_access_in), .p0_in(p0_wire), .p0_out(p0_out),
      .p0_oe_b_out(p0_oe_b_out), .p2_out(p2_out), .rd_b_out(rd_b_out),
      .wr_b_out(wr_b_out), .ram_disable_out(ram_disable_out));
   xdr_ext_mem u_mem (.clk_in(mclk_in), .p0_in(p0_wire), .p2_in(p2_out),
      .rd_b_in(rd_b_out), .wr_b_in(wr_b_out), .data_out(mem_data));
   //------------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp, got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic sfr(input logic wr, input logic [7:0] a, d);
      @(posedge mclk_in) #1;
      sfr_wr_in = wr;
      sfr_rd_in = !wr;
      sfr_addr_in = a;
      sfr_wdata_in = d;
      @(posedge mclk_in) #1;
      sfr_wr_in = 0;
      sfr_rd_in = 0;
      rdat = sfr_rdata_out;
   endtask
   task automatic rel_rst;
      repeat (2) @(posedge mclk_in);
      #1 rst_b_in = 1;
      repeat (3) @(posedge mclk_in);
   endtask
   // Reset may be pulled in cycle one or two of the move (rs = 1 or 2).
   task automatic mv(input logic w, wr, input logic [15:0] a,
                     input logic [7:0] d, input int rs);
      @(posedge mclk_in) #1;
      move_start_in = 1;
      move_wide_in = w;
      move_write_in = wr;
      wide_ptr_in = a;
      short_ptr_in = a[7:0];
      acc_wdata_in = d;
      @(posedge mclk_in) #1;
      move_start_in = 0;
      c1_p0 = p0_out;
      c1_p2 = p2_out;
      if (rs == 1)
         rst_b_in = 0;
      @(posedge mclk_in) #1;
      c2_p0 = p0_out;
      c2_rd = rd_b_out;
      c2_wr = wr_b_out;
      c2_oe = p0_oe_b_out;
      if (rs == 2)
         rst_b_in = 0;
      vld = 0;
      repeat (3) begin
         @(posedge mclk_in) #1;
         if (acc_valid_out === 1'b1) begin
            vld = 1;
            rdat = acc_rdata_out;
         end
      end
   endtask
   task automatic rd_ram(input logic [15:0] a, input logic [7:0] e);
      mv(1, 0, a, 8'h00, 0);
      chk("ram read valid", 1'b1, vld);
      chk("ram read data", e, rdat);
      chk("ram read p0 drive", 1'b0, c2_oe);
      chk("ram read on p0", e, c2_p0);
   endtask
   //------------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------------
   task automatic t_reset_and_disabled;
      chk("disable after reset", 1'b1, ram_disable_out);
      sfr(0, SFR_PAGE, 0);
      chk("page reset", PAGE_RST, rdat);
      sfr(0, 8'h55, 0);
      chk("unmapped read", ZERO_BYTE, rdat);
      // RAM stays disabled so this window belongs to external memory.
      mv(1, 1, 16'hF900, 8'h3C, 0);
      chk("disabled wide strobe", 1'b0, c2_wr);
      chk("disabled wide high", 8'hF9, c1_p2);
      chk("ext mem wide", 8'h3C, u_mem.mem[16'hF900]);
      sfr(1, SFR_PORT2, 8'hF8);
      mv(0, 1, 16'h0010, 8'h77, 0);
      chk("disabled short strobe", 1'b0, c2_wr);
      chk("disabled short low", 8'h10, c1_p0);
      mv(0, 0, 16'h0010, 8'h00, 0);
      chk("disabled short read", 8'h77, rdat);
      chk("ext read p0 float", 1'b1, c2_oe);
      $display("test reset_and_disabled done");
   endtask
   task automatic t_pages_enable;
      sfr(1, SFR_PORT2, 8'hAA);
      chk("port2 latch", 8'hAA, p2_out);
      sfr(0, SFR_PAGE, 0);
      chk("page follows port2", 8'hAA, rdat);
      sfr(1, SFR_PAGE, 8'hF8);
      chk("port2 kept", 8'hAA, p2_out);
      sfr(0, SFR_PAGE, 0);
      chk("page only", 8'hF8, rdat);
      sfr(1, SFR_SYSCTL, 8'h00);
      sfr(1, SFR_SYSCTL, 8'h01);
      chk("disable cannot return", 1'b0, ram_disable_out);
      $display("test pages_enable done");
   endtask
   task automatic t_ram_routes;
      mv(0, 1, 16'h0030, 8'h5A, 0);
      chk("ram no strobe", 1'b1, c2_wr & c2_rd);
      chk("ram addr on p0", 8'h30, c1_p0);
      chk("ram data on p0", 8'h5A, c2_p0);
      chk("port2 io", 8'hAA, c1_p2);
      rd_ram(16'hF830, 8'h5A);
      chk("wide high on p2", 8'hF8, c1_p2);
      mv(1, 1, 16'hF900, 8'h66, 0);
      chk("ram keeps ext", 8'h3C, u_mem.mem[16'hF900]);
      rd_ram(16'hF900, 8'h66);
      mv(1, 1, 16'hF7FF, 8'h11, 0);
      chk("below range strobe", 1'b0, c2_wr);
      chk("below range mem", 8'h11, u_mem.mem[16'hF7FF]);
      sfr(1, SFR_PORT2, 8'h12);
      mv(0, 1, 16'h0040, 8'h99, 0);
      chk("short ext strobe", 1'b0, c2_wr);
      chk("short ext p2 io", 8'h12, c1_p2);
      chk("short ext mem", 8'h99, u_mem.mem[16'h1240]);
      sfr(1, SFR_PAGE, 8'hF8);
      mv(0, 0, 16'h0030, 8'h00, 0);
      chk("short ram read", 8'h5A, rdat);
      $display("test ram_routes done");
   endtask
   task automatic t_visible_pin;
      sfr(1, SFR_SYSCTL, 8'h02);
      mv(1, 1, 16'hF840, 8'h21, 0);
      chk("visible strobe", 1'b0, c2_wr);
      chk("visible data", 8'h21, c2_p0);
      mv(0, 0, 16'h0030, 8'h00, 0);
      chk("visible rd strobe", 1'b0, c2_rd);
      chk("visible p2 io", 8'h12, c1_p2);
      chk("visible ram data", 8'h5A, rdat);
      chk("visible rd drive", 1'b0, c2_oe);
      mv(1, 0, 16'hF7FF, 8'h00, 0);
      chk("visible off range", 8'h11, rdat);
      sfr(1, SFR_SYSCTL, 8'h00);
      sfr(1, SFR_PORT0, 8'h5C);
      @(posedge mclk_in) #1;
      ext_access_in = 1;
      mv(0, 1, 16'h0031, 8'h4B, 0);
      chk("pin high p0 c1", 8'h5C, c1_p0);
      chk("pin high p0 c2", 8'h5C, c2_p0);
      chk("pin high strobe", 1'b1, c2_wr);
      @(posedge mclk_in) #1;
      ext_access_in = 0;
      $display("test visible_pin done");
   endtask
   task automatic t_reset_mid;
      mv(1, 1, 16'hF830, 8'hE1, 1);
      rel_rst();
      chk("disable set again", 1'b1, ram_disable_out);
      // Visibility set while disabled must not pull the window inside.
      sfr(1, SFR_SYSCTL, 8'h03);
      mv(1, 1, 16'hF830, 8'hC3, 0);
      chk("visible while disabled", 1'b0, c2_wr);
      chk("disabled window ext", 8'hC3, u_mem.mem[16'hF830]);
      sfr(1, SFR_SYSCTL, 8'h00);
      rd_ram(16'hF830, 8'h5A);
      mv(1, 1, 16'hF830, 8'hE2, 2);
      rel_rst();
      sfr(1, SFR_SYSCTL, 8'h00);
      rd_ram(16'hF830, 8'hE2);
      $display("test reset_mid done");
   endtask
   //------------------------------------------------------------------
   // Main sequence and watchdog
   //------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge mclk_in);
      #1 rst_b_in = 1;
      repeat (3) @(posedge mclk_in);
      t_reset_and_disabled();
      t_pages_enable();
      t_ram_routes();
      t_visible_pin();
      t_reset_mid();
      summarize();
   end
   // The tests take well under 1000 cycles; this allows ample margin.
   initial begin
      #100000;
      n_fail++;
      summarize();
   end
endmodule

// ### verif/xdr_ext_mem.sv
// External data memory model on the multiplexed port 0/port 2 bus.
`timescale 1ns/1ps
module xdr_ext_mem (
   input  wire logic       clk_in,   // Bus clock.
   input  wire logic [7:0] p0_in,    // Port 0 wire level.
   input  wire logic [7:0] p2_in,    // Port 2 drive from the block.
   input  wire logic       rd_b_in,  // Read strobe, active low.
   input  wire logic       wr_b_in,  // Write strobe, active low.
   output logic      [7:0] data_out  // Data this memory puts on port 0.
);
   logic [7:0]  mem [0:65535];
   logic [15:0] addr_q;
   logic [7:0]  last_q = 8'h00;
   //------------------------------------------------------------------
   // Bus cycle
   //------------------------------------------------------------------
   // The address is what the ports carried in the cycle before a strobe.
   always @(posedge clk_in) begin
      if (rd_b_in && wr_b_in)
         addr_q <= {p2_in, p0_in};
      if (!wr_b_in)
         mem[addr_q] <= p0_in;
   end
   // Off the strobe nothing holds the bus, so the old byte is not kept.
   assign data_out = !rd_b_in ? mem[addr_q] : ~last_q;
   always @(posedge clk_in) last_q <= data_out;
endmodule
